// >>> bench/mra_core_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Core memory stand-in: one 18-bit word per cycle, prompt or slow
module mra_core_mem (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [17:0] mem_addr,
    input  wire logic [17:0] mem_wdata,
    output logic [17:0]      mem_rdata,
    output logic             mem_ack
);
    logic [17:0] mem [262144];
    logic [2:0]  wait_cnt;
    // Known fill so every operand read has a predictable value
    initial begin
        for (int i = 0; i < 262144; i++) begin
            mem[i] = 18'(i) ^ 18'h2d2d2;
        end
    end
    // Plain always so the bench can also preload words directly
    always @(posedge core_clk) begin
        if (sys_rst) begin
            mem_ack   <= 1'b0;
            mem_rdata <= 18'h00000;
            wait_cnt  <= 3'h0;
        end else if (mem_req && !mem_ack && wait_cnt >= (slow ? 3'h5 : 3'h0)) begin
            mem_ack  <= 1'b1;
            wait_cnt <= 3'h0;
            if (mem_we) begin
                mem[mem_addr] <= mem_wdata;
            end else begin
                mem_rdata <= mem[mem_addr];
            end
        end else begin
            // Data lines do not hold once the cycle is over
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_cnt  <= (mem_req && !mem_ack) ? wait_cnt + 3'h1 : 3'h0;
        end
    end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import mra_pkg::*;
    typedef struct packed {
        logic [17:0] ip;
        logic [17:0] instr;
        logic [17:0] ea;
        logic [17:0] nip;
    } mra_row_t;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        slow = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, mem_req, mem_we, mem_ack;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, v;
    logic [17:0] mem_addr, mem_wdata, mem_rdata;
    int          failures = 0, check_count = 0, cyc = 0, dur;
    logic [7:0]  rst_regs [4] = '{REG_SWITCH, REG_IP, REG_INDEX, REG_LIMIT};
    mra_row_t    rows [8] = '{
        '{18'h01000, 18'h00123, 18'h01123, 18'h01001}, '{18'h01000, 18'h01123, 18'h11123, 18'h01001},
        '{18'h01000, 18'h02200, 18'h05567, 18'h01001}, '{18'h01000, 18'h03200, 18'h15567, 18'h01001},
        '{18'h01fff, 18'h00010, 18'h01010, 18'h01000}, '{18'h02000, 18'h30345, 18'h02345, 18'h02345},
        '{18'h01000, 18'h32200, 18'h05567, 18'h05567}, '{18'h01000, 18'h31123, 18'h11123, 18'h11123}};
    mra_unit uut (.core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack));
    mra_core_mem mem (.core_clk(core_clk), .sys_rst(sys_rst), .slow(slow), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack));
    // 50 MHz clock
    always #10 core_clk = ~core_clk;
    // Hang guard, far above the under a thousand cycles the tests need
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            close_out();
        end
    end
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Handshakes are judged at the falling edge, released after the rising one
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        logic aw_hs, w_hs, b_hs;
        b_hs = 1'b0;
        @(posedge core_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!b_hs) begin
            @(negedge core_clk);
            aw_hs = awvalid & awready;
            w_hs  = wvalid & wready;
            b_hs  = (bvalid === 1'b1);
            rs    = bresp;
            @(posedge core_clk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        logic ar_hs, r_hs;
        r_hs = 1'b0;
        @(posedge core_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!r_hs) begin
            @(negedge core_clk);
            ar_hs = arvalid & arready;
            r_hs  = (rvalid === 1'b1);
            d     = rdata;
            rs    = rresp;
            @(posedge core_clk);
            if (ar_hs) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask
    task automatic setip(input logic [17:0] ip);
        logic [1:0] rs;
        wr(REG_SWITCH, {14'h0, ip}, rs);
        wr(REG_CTRL, 32'h2, rs);
    endtask
    task automatic step(output int d);
        logic [1:0]  rs;
        logic [31:0] c, s;
        int          t0;
        t0 = cyc;
        wr(REG_CTRL, 32'h1, rs);
        do begin
            rd(REG_CTRL, c, rs);
            rd(REG_STATUS, s, rs);
        end while (c[CTRL_STEP] | s[ST_BUSY]);
        d = cyc - t0;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        // Reset values and the unmapped hole
        foreach (rst_regs[i]) begin
            rd(rst_regs[i], v, r);
            chk("reset reg", v, 32'h0);
        end
        rd(8'h40, v, r);
        chk("unmapped rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h40, 32'h1, r);
        chk("unmapped bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
        $display("test reset done");
        // Table of address modes and jumps
        mem.mem[18'h01200] = 18'h3d567;
        wr(REG_INDEX, 32'h10000, r);
        foreach (rows[i]) begin
            setip(rows[i].ip);
            mem.mem[rows[i].ip] = rows[i].instr;
            step(dur);
            rd(REG_EA, v, r);
            chk("ea", v, {14'h0, rows[i].ea});
            rd(REG_IP, v, r);
            chk("ip", v, {14'h0, rows[i].nip});
            if (rows[i].instr[17:14] != OP_JMP) begin
                rd(REG_DATA, v, r);
                chk("data", v, {14'h0, rows[i].ea ^ 18'h2d2d2});
                chk("slow mode", {31'h0, dur >= IND_CYC}, {31'h0, rows[i].instr[13]});
            end
        end
        $display("test rows done");
        // Auto-increment through page 0, memory slow
        slow <= 1'b1;
        setip(18'h00100);
        mem.mem[18'h00100] = 18'h02008;
        mem.mem[18'h00101] = 18'h02008;
        mem.mem[18'h00102] = 18'h00008;
        mem.mem[18'h00008] = 18'h00500;
        step(dur);
        rd(REG_EA, v, r);
        chk("ainc ea 1", v, 32'h00501);
        chk("ainc word", {14'h0, mem.mem[18'h00008]}, 32'h00501);
        step(dur);
        rd(REG_EA, v, r);
        chk("ainc ea 2", v, 32'h00502);
        rd(REG_DATA, v, r);
        chk("ainc data", v, {14'h0, 18'h00502 ^ 18'h2d2d2});
        step(dur);
        rd(REG_EA, v, r);
        chk("plain ea", v, 32'h00008);
        rd(REG_DATA, v, r);
        chk("plain data", v, 32'h00502);
        slow <= 1'b0;
        $display("test autoinc done");
        // Add to index and skip, then a non-memory code
        wr(REG_INDEX, 32'h10, r);
        wr(REG_LIMIT, 32'h12, r);
        setip(18'h01000);
        mem.mem[18'h01000] = 18'h38003;
        mem.mem[18'h01002] = 18'h380fe;
        mem.mem[18'h01003] = 18'h34000;
        step(dur);
        rd(REG_INDEX, v, r);
        chk("index up", v, 32'h13);
        rd(REG_IP, v, r);
        chk("skip ip", v, 32'h01002);
        rd(REG_STATUS, v, r);
        chk("skip flag", {31'h0, v[ST_SKIP]}, 32'h1);
        step(dur);
        rd(REG_INDEX, v, r);
        chk("index down", v, 32'h11);
        rd(REG_IP, v, r);
        chk("no skip ip", v, 32'h01003);
        step(dur);
        rd(REG_STATUS, v, r);
        chk("nmr flag", {31'h0, v[ST_NMR]}, 32'h1);
        chk("status opcode", {28'h0, v[ST_OPC_LO+3:ST_OPC_LO]}, 32'hd);
        rd(REG_INSTR, v, r);
        chk("instr word", v, 32'h34000);
        $display("test index skip done");
        // Mid-run reset must clear the pointer, index and limit again
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        foreach (rst_regs[i]) begin
            rd(rst_regs[i], v, r);
            chk("rerun reset reg", v, 32'h0);
        end
        // Only the low byte lane is strobed, so the upper bits stay clear
        wstrb <= 4'h1;
        wr(REG_SWITCH, 32'h3ffff, r);
        wstrb <= 4'hf;
        rd(REG_SWITCH, v, r);
        chk("lane merge", v, 32'h000ff);
        $display("test mid reset done");
        close_out();
    end
endmodule
`default_nettype wire

// >>> logic/mra_pkg.sv
package mra_pkg;
    localparam int          WORD_W      = 18;
    localparam int          AXI_AW      = 8;
    // Register byte offsets
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_SWITCH  = 8'h04;
    localparam logic [7:0]  REG_IP      = 8'h08;
    localparam logic [7:0]  REG_INDEX   = 8'h0c;
    localparam logic [7:0]  REG_LIMIT   = 8'h10;
    localparam logic [7:0]  REG_STATUS  = 8'h14;
    localparam logic [7:0]  REG_EA      = 8'h18;
    localparam logic [7:0]  REG_INSTR   = 8'h1c;
    localparam logic [7:0]  REG_DATA    = 8'h20;
    // Control and status bit positions
    localparam int          CTRL_STEP   = 0;
    localparam int          CTRL_LOAD   = 1;
    localparam int          ST_BUSY     = 0;
    localparam int          ST_SKIP     = 1;
    localparam int          ST_NMR      = 2;
    localparam int          ST_MODE_LO  = 4;
    localparam int          ST_OPC_LO   = 8;
    // Instruction fields, vector bit = 17 - documented bit
    localparam int          OPC_LO      = 14;
    localparam int          MODE_LO     = 12;
    localparam int          PAGE_LO     = 12;
    localparam int          BLOCK_LO    = 15;
    // Address modes
    localparam logic [1:0]  MODE_DIR    = 2'h0;
    localparam logic [1:0]  MODE_IDX    = 2'h1;
    localparam logic [1:0]  MODE_IND    = 2'h2;
    localparam logic [1:0]  MODE_INDX   = 2'h3;
    // Opcodes: d, e, f are the non-memory classes, e is index operate
    localparam logic [3:0]  OP_JMP      = 4'hc;
    localparam logic [3:0]  OP_NMR_MIN  = 4'hd;
    localparam logic [3:0]  OP_IDX_SKIP = 4'he;
    // Auto-increment window in page 0
    localparam logic [11:0] AINC_LO     = 12'h008;
    localparam logic [11:0] AINC_HI     = 12'h00f;
    // Timing
    localparam int          CLK_NS      = 20;
    localparam int          T_IND_NS    = 800;
    localparam int          IND_CYC     = (T_IND_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        S_IDLE, S_FETCH, S_DECODE, S_PTR, S_AINC, S_IWAIT, S_OPER
    } mra_state_t;
endpackage

// >>> logic/mra_unit.sv
`timescale 1ns/1ps
`default_nettype none
module mra_unit (
    input  wire logic                       core_clk,
    input  wire logic                       sys_rst,
    input  wire logic [mra_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [mra_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output logic                            mem_req,
    output logic                            mem_we,
    output logic [mra_pkg::WORD_W-1:0]      mem_addr,
    output logic [mra_pkg::WORD_W-1:0]      mem_wdata,
    input  wire logic [mra_pkg::WORD_W-1:0] mem_rdata,
    input  wire logic                       mem_ack
);
    import mra_pkg::*;

    typedef struct packed {
        mra_state_t         st;
        logic [WORD_W-1:0]  ip;
        logic [WORD_W-1:0]  xr;
        logic [WORD_W-1:0]  lim;
        logic [WORD_W-1:0]  sw;
        logic [WORD_W-1:0]  ir;
        logic [WORD_W-1:0]  ea;
        logic [WORD_W-1:0]  ptr;
        logic [WORD_W-1:0]  data;
        logic               skip;
        logic               nmr;
        logic               pend;
        logic [7:0]         cnt;
        logic               mreq;
        logic               mwe;
        logic [WORD_W-1:0]  maddr;
        logic [WORD_W-1:0]  mwdata;
        logic               aw_ok;
        logic [AXI_AW-1:0]  aw_addr;
        logic               w_ok;
        logic [31:0]        w_data;
        logic [3:0]         w_strb;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
    } mra_regs_t;

    localparam logic [7:0] IND_LAST = 8'(IND_CYC - 1);

    mra_regs_t r_r;
    mra_regs_t r_nxt;

    // Byte-lane merge of a bus write into an 18-bit register
    function automatic logic [WORD_W-1:0] wr18(logic [WORD_W-1:0] old, logic [31:0] d,
                                               logic [3:0] s);
        logic [WORD_W-1:0] v;
        v = old;
        if (s[0]) v[7:0] = d[7:0];
        if (s[1]) v[15:8] = d[15:8];
        if (s[2]) v[17:16] = d[17:16];
        return v;
    endfunction

    // Page 0 auto-increment cells
    function automatic logic is_ainc(logic [WORD_W-1:0] a);
        return (a[WORD_W-1:PAGE_LO] == '0) && (a[11:0] >= AINC_LO) && (a[11:0] <= AINC_HI);
    endfunction

    // Final effective address: either a jump or an operand cycle follows
    function automatic mra_regs_t finish_ea(mra_regs_t s, logic [WORD_W-1:0] ea);
        mra_regs_t t;
        t = s;
        t.ea = ea;
        if (s.ir[WORD_W-1:OPC_LO] == OP_JMP) begin
            case (s.ir[13:MODE_LO])
                MODE_DIR: t.ip = {s.ip[WORD_W-1:PAGE_LO], ea[11:0]};
                MODE_IND: t.ip = {s.ip[WORD_W-1:BLOCK_LO], ea[14:0]};
                default:  t.ip = {s.ip[WORD_W-1], ea[16:0]};
            endcase
            t.st = S_IDLE;
        end else begin
            // Last memory cycle, after the fetch and any pointer access, reads the operand
            t.mreq  = 1'b1;
            t.mwe   = 1'b0;
            t.maddr = ea;
            t.st    = S_OPER;
        end
        return t;
    endfunction

    // Instruction fields, vector bit 17 is the word's bit 0
    logic [3:0]        opc;
    logic [1:0]        mode;
    logic [11:0]       ir_addr;
    logic [WORD_W-1:0] cpa;
    logic [WORD_W-1:0] ind_ea;
    logic [WORD_W-1:0] idx_imm;
    logic [WORD_W-1:0] xr_sum;
    logic [WORD_W-1:0] ip_wrap;
    assign opc     = r_r.ir[WORD_W-1:OPC_LO];
    assign mode    = r_r.ir[13:MODE_LO];
    assign ir_addr = r_r.ir[11:0];
    assign cpa     = {r_r.ip[WORD_W-1:PAGE_LO], ir_addr};
    assign ind_ea  = {r_r.ip[WORD_W-1:BLOCK_LO], r_r.ptr[14:0]};
    assign idx_imm = {{10{r_r.ir[7]}}, r_r.ir[7:0]};
    assign xr_sum  = r_r.xr + idx_imm;
    // Counter covers only the low 12 bits; no carry into page bits
    assign ip_wrap = {r_r.ip[WORD_W-1:PAGE_LO], r_r.ip[11:0] + 12'h001};

    // Handshake outputs straight from state
    assign s_axi_awready = !r_r.aw_ok && !r_r.bvalid;
    assign s_axi_wready  = !r_r.w_ok && !r_r.bvalid;
    assign s_axi_arready = !r_r.rvalid;
    assign s_axi_bvalid  = r_r.bvalid;
    assign s_axi_bresp   = r_r.bresp;
    assign s_axi_rvalid  = r_r.rvalid;
    assign s_axi_rdata   = r_r.rdata;
    assign s_axi_rresp   = r_r.rresp;
    assign mem_req       = r_r.mreq;
    assign mem_we        = r_r.mwe;
    assign mem_addr      = r_r.maddr;
    assign mem_wdata     = r_r.mwdata;

    // Whole next state; sequencer first so bus writes after it win where allowed
    always_comb begin
        r_nxt = r_r;
        case (r_r.st)
            S_IDLE: begin
                if (r_r.pend) begin
                    r_nxt.pend  = 1'b0;
                    r_nxt.mreq  = 1'b1;
                    r_nxt.mwe   = 1'b0;
                    r_nxt.maddr = r_r.ip;
                    r_nxt.st    = S_FETCH;
                end
            end
            S_FETCH: begin
                if (mem_ack) begin
                    r_nxt.mreq = 1'b0;
                    r_nxt.ir   = mem_rdata;
                    r_nxt.ip   = ip_wrap;
                    r_nxt.skip = 1'b0;
                    r_nxt.st   = S_DECODE;
                end
            end
            S_DECODE: begin
                r_nxt.nmr = (opc >= OP_NMR_MIN);
                r_nxt.cnt = '0;
                if (opc == OP_IDX_SKIP) begin
                    r_nxt.xr = xr_sum;
                    if ($signed(xr_sum) > $signed(r_r.lim)) begin
                        r_nxt.skip = 1'b1;
                        r_nxt.ip   = ip_wrap;
                    end
                    r_nxt.st = S_IDLE;
                end else if (opc >= OP_NMR_MIN) begin
                    r_nxt.st = S_IDLE;
                end else if (mode == MODE_DIR) begin
                    r_nxt = finish_ea(r_nxt, cpa);
                end else if (mode == MODE_IDX) begin
                    r_nxt = finish_ea(r_nxt, cpa + r_r.xr);
                end else begin
                    // Single pointer read; its contents are never re-indirected
                    r_nxt.mreq  = 1'b1;
                    r_nxt.mwe   = 1'b0;
                    r_nxt.maddr = cpa;
                    r_nxt.st    = S_PTR;
                end
            end
            S_PTR: begin
                r_nxt.cnt = r_r.cnt + 8'h01;
                if (mem_ack) begin
                    if (is_ainc(r_r.maddr)) begin
                        r_nxt.ptr    = mem_rdata + 18'h00001;
                        r_nxt.mwe    = 1'b1;
                        r_nxt.mwdata = mem_rdata + 18'h00001;
                        r_nxt.st     = S_AINC;
                    end else begin
                        r_nxt.ptr  = mem_rdata;
                        r_nxt.mreq = 1'b0;
                        r_nxt.st   = S_IWAIT;
                    end
                end
            end
            S_AINC: begin
                r_nxt.cnt = r_r.cnt + 8'h01;
                if (mem_ack) begin
                    r_nxt.mreq = 1'b0;
                    r_nxt.mwe  = 1'b0;
                    r_nxt.st   = S_IWAIT;
                end
            end
            S_IWAIT: begin
                // Pads indirect modes to the documented extra time
                r_nxt.cnt = r_r.cnt + 8'h01;
                if (r_r.cnt >= IND_LAST) begin
                    if (mode == MODE_INDX) begin
                        r_nxt = finish_ea(r_r, ind_ea + r_r.xr);
                    end else begin
                        r_nxt = finish_ea(r_r, ind_ea);
                    end
                end
            end
            S_OPER: begin
                if (mem_ack) begin
                    r_nxt.mreq = 1'b0;
                    r_nxt.data = mem_rdata;
                    r_nxt.st   = S_IDLE;
                end
            end
            default: r_nxt.st = S_IDLE;
        endcase

        // AXI write: address and data latch independently
        if (s_axi_awvalid && s_axi_awready) begin
            r_nxt.aw_ok   = 1'b1;
            r_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            r_nxt.w_ok   = 1'b1;
            r_nxt.w_data = s_axi_wdata;
            r_nxt.w_strb = s_axi_wstrb;
        end
        if (r_r.bvalid && s_axi_bready) begin
            r_nxt.bvalid = 1'b0;
        end
        if (r_r.aw_ok && r_r.w_ok) begin
            r_nxt.aw_ok  = 1'b0;
            r_nxt.w_ok   = 1'b0;
            r_nxt.bvalid = 1'b1;
            r_nxt.bresp  = RESP_OKAY;
            // Sequencer-owned registers only change while idle, so no race
            case (r_r.aw_addr)
                REG_CTRL: begin
                    if (r_r.w_strb[0] && r_r.w_data[CTRL_STEP]) begin
                        r_nxt.pend = 1'b1;
                    end
                    if (r_r.w_strb[0] && r_r.w_data[CTRL_LOAD] && r_r.st == S_IDLE) begin
                        r_nxt.ip = r_r.sw;
                    end
                end
                REG_SWITCH: r_nxt.sw = wr18(r_r.sw, r_r.w_data, r_r.w_strb);
                REG_INDEX: begin
                    if (r_r.st == S_IDLE) r_nxt.xr = wr18(r_r.xr, r_r.w_data, r_r.w_strb);
                end
                REG_LIMIT: begin
                    if (r_r.st == S_IDLE) r_nxt.lim = wr18(r_r.lim, r_r.w_data, r_r.w_strb);
                end
                REG_IP, REG_STATUS, REG_EA, REG_INSTR, REG_DATA: r_nxt.bresp = RESP_OKAY;
                default: r_nxt.bresp = RESP_SLVERR;
            endcase
        end

        // AXI read: one cycle from address to data
        if (r_r.rvalid && s_axi_rready) begin
            r_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            r_nxt.rvalid = 1'b1;
            r_nxt.rresp  = RESP_OKAY;
            r_nxt.rdata  = '0;
            case (s_axi_araddr)
                REG_CTRL:   r_nxt.rdata[CTRL_STEP] = r_r.pend;
                REG_SWITCH: r_nxt.rdata[WORD_W-1:0] = r_r.sw;
                REG_IP:     r_nxt.rdata[WORD_W-1:0] = r_r.ip;
                REG_INDEX:  r_nxt.rdata[WORD_W-1:0] = r_r.xr;
                REG_LIMIT:  r_nxt.rdata[WORD_W-1:0] = r_r.lim;
                REG_STATUS: begin
                    r_nxt.rdata[ST_BUSY]                  = (r_r.st != S_IDLE);
                    r_nxt.rdata[ST_SKIP]                  = r_r.skip;
                    r_nxt.rdata[ST_NMR]                   = r_r.nmr;
                    r_nxt.rdata[ST_MODE_LO+1:ST_MODE_LO]  = mode;
                    r_nxt.rdata[ST_OPC_LO+3:ST_OPC_LO]    = opc;
                end
                REG_EA:     r_nxt.rdata[WORD_W-1:0] = r_r.ea;
                REG_INSTR:  r_nxt.rdata[WORD_W-1:0] = r_r.ir;
                REG_DATA:   r_nxt.rdata[WORD_W-1:0] = r_r.data;
                default:    r_nxt.rresp = RESP_SLVERR;
            endcase
        end
    end

    // Single state register, synchronous reset
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    logic [WORD_W-1:0] ip_q;
    assign ip_q = r_r.ip;

    property p_ip_wrap;
        (r_r.st == S_FETCH && mem_ack) |=>
            (ip_q[11:0] == 12'($past(ip_q) + 18'h00001)) && (ip_q[17:12] == $past(ip_q[17:12]));
    endproperty
    a_ip_wrap: assert property (p_ip_wrap) else $error("pointer advance wrong");

    property p_fetch_at_ip;
        (r_r.st == S_FETCH) |-> (mem_req && !mem_we && mem_addr == r_r.ip);
    endproperty
    a_fetch_at_ip: assert property (p_fetch_at_ip) else $error("fetch not at pointer");

    property p_direct;
        (r_r.st == S_DECODE && opc < OP_NMR_MIN && opc != OP_JMP && mode == MODE_DIR) |=>
            (mem_req && mem_addr == {$past(ip_q[17:12]), $past(ir_addr)});
    endproperty
    a_direct: assert property (p_direct) else $error("direct address wrong");

    property p_indexed;
        (r_r.st == S_DECODE && opc < OP_NMR_MIN && opc != OP_JMP && mode == MODE_IDX) |=>
            (r_r.st == S_OPER && mem_addr == $past(cpa) + $past(r_r.xr));
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");

    property p_ind_delay;
        (r_r.st == S_DECODE && opc < OP_NMR_MIN && mode[1]) |=> (r_r.st != S_OPER)[*8] ##1
            (r_r.st != S_OPER)[*8] ##1 (r_r.st != S_OPER)[*8] ##1 (r_r.st != S_OPER)[*8];
    endproperty
    a_ind_delay: assert property (p_ind_delay) else $error("indirect too fast");

    property p_ainc_wb;
        (r_r.st == S_PTR && mem_ack && is_ainc(mem_addr)) |=>
            (mem_we && mem_wdata == $past(mem_rdata) + 18'h00001 && mem_addr == $past(mem_addr));
    endproperty
    a_ainc_wb: assert property (p_ainc_wb) else $error("auto-increment write-back");

    property p_ind_addr;
        (r_r.st == S_IWAIT && r_nxt.st == S_OPER && mode == MODE_IND) |=>
            (mem_addr == {ip_q[17:15], r_r.ptr[14:0]});
    endproperty
    a_ind_addr: assert property (p_ind_addr) else $error("indirect address wrong");

    property p_idx_skip;
        (r_r.st == S_DECODE && opc == OP_IDX_SKIP) |=>
            (r_r.xr == $past(xr_sum)) && (r_r.skip == ($signed(r_r.xr) > $signed(r_r.lim)));
    endproperty
    a_idx_skip: assert property (p_idx_skip) else $error("index add and skip wrong");

    property p_jmp_ind;
        (r_r.st == S_IWAIT && r_nxt.st == S_IDLE && mode == MODE_IND) |=>
            (ip_q[17:15] == $past(ip_q[17:15])) && (ip_q[14:0] == $past(r_r.ptr[14:0]));
    endproperty
    a_jmp_ind: assert property (p_jmp_ind) else $error("jump indirect wrong");

    c_ainc: cover property (r_r.st == S_AINC && mem_ack);
    c_skip: cover property (r_r.st == S_DECODE && opc == OP_IDX_SKIP ##1 r_r.skip);
    c_indx: cover property (r_r.st == S_IWAIT && mode == MODE_INDX ##1 r_r.st == S_OPER);
    c_jump: cover property (r_r.st == S_DECODE && opc == OP_JMP ##1 r_r.st == S_IDLE);
endmodule
`default_nettype wire
